// file: hw/slcd_controller.sv
`timescale 1ns/10ps

// Summary of operation
// (R01) Internal driver serves 32 segments; expansion reaches 256 at static duty.
// (R02) At 1/2 duty the expansion path carries 128 segments per line.
// (R03) At 1/3 or 1/4 duty the expansion path carries 64 segments per line.
// (R04) Display memory is 32 bytes of 8 bits, 256 bits in all.
// (R05) Display memory takes byte and 16-bit writes like ordinary memory.
// (R06) Segment pins switch to port use in groups of eight.
// (R07) At static or 1/2 duty unused commons can mirror used ones.
// (R08) Refresh runs in every mode except chip standby and module standby.
// (R09) Eleven clock choices set the frame frequency.
// (R10) A module standby input stops the controller on its own.
// (R11) Software picks waveform A or B.
// (R12) Port and duty control register resets to 00.
// (R13) Drive control register resets to 80.
// (R14) Waveform and power control register resets to 60.
// (R15) In expansion the top segment pin carries the latch clock.
// (R16) In expansion the second segment pin carries the shift clock.
// (R17) In expansion the pin of segment 29 carries the alternation signal.
// (R18) In expansion the pin of segment 30 carries serial display data.
// (R19) Refresh starts from display memory once the display is enabled.
// (R20) Memory-to-segment mapping follows the selected duty.
// (R21) Clearing the enable halts the block and drops power, keeping registers.
// (R22) Display bit set shows memory, cleared shows blank.
// (R23) Expansion select takes pins 32 to 29; illegal with any driver group.
// (R24) Waveform select clear gives A, set gives B.
// (R25) Expansion shifts one bit per shift clock, then one latch pulse per line.
// (R26) Alternation toggles per frame for A, per line for B.
module slcd_controller (
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic [17:0] avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        standby_mode,
  input  wire logic        module_standby,
  input  wire logic        subclk_in,
  output logic      [31:0] seg_pin,
  output logic      [31:0] seg_port_mode,
  output logic      [3:0]  com_pin,
  output logic             drive_power_on,
  output logic             supply_boost,
  output logic      [3:0]  charge_duty
);

  ////////////////////////////////////////////////////////////////////////////
  // Decode helpers.

  // Bit of the flat display memory for a segment on a common line.
  function automatic logic [7:0] ram_index(input logic [8:0] seg,
                                           input logic [1:0] com,
                                           input slcd_pkg::slcd_duty_type duty);
    logic [9:0] wide;
    wide = 10'h000;
    unique case (duty)
      slcd_pkg::DUTY_STATIC: wide = {1'b0, seg};
      slcd_pkg::DUTY_HALF:   wide = {seg, com[0]};
      slcd_pkg::DUTY_THIRD,
      slcd_pkg::DUTY_QUARTER: wide = {seg[7:0], com};
    endcase
    return wide[7:0];
  endfunction

  function automatic logic [8:0] exp_cap(input slcd_pkg::slcd_duty_type duty);
    logic [8:0] cap;
    cap = slcd_pkg::CAP_MULTI;
    unique case (duty)
      slcd_pkg::DUTY_STATIC: cap = slcd_pkg::CAP_STATIC;
      slcd_pkg::DUTY_HALF:   cap = slcd_pkg::CAP_HALF;
      slcd_pkg::DUTY_THIRD,
      slcd_pkg::DUTY_QUARTER: cap = slcd_pkg::CAP_MULTI;
    endcase
    return cap;
  endfunction

  // Groups of eight pins driven as segments, top group first.
  function automatic logic [3:0] drv_groups(input logic [3:0] sgs);
    logic [3:0] g;
    g = 4'h0;
    if (sgs[3]) begin
      g = 4'hf;
    end else begin
      unique case (sgs[2:1])
        2'b00: g = 4'h0;
        2'b01: g = 4'h8;
        2'b10: g = 4'hc;
        2'b11: g = 4'he;
      endcase
    end
    return g;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Registers and memory.
  slcd_pkg::slcd_pdc_type   pdc_q;
  slcd_pkg::slcd_dc_type    dc_q;
  slcd_pkg::slcd_wpc_type   wpc_q;
  slcd_pkg::slcd_state_type state_q;
  logic [7:0]  ram_q [slcd_pkg::RAM_BYTES];
  logic [255:0] ram_flat;
  logic        ack_q;
  logic [31:0] rdata_q;
  logic        req;
  logic        hit_ram;
  logic        hit_pdc;
  logic        hit_dc;
  logic        hit_wpc;
  logic [2:0]  word_idx;
  logic [7:0]  wbyte;

  assign req      = avs_read | avs_write;
  assign hit_ram  = avs_address < slcd_pkg::RAM_LIMIT;
  assign hit_pdc  = avs_address == {slcd_pkg::IDX_PDC, 2'b00};
  assign hit_dc   = avs_address == {slcd_pkg::IDX_DC, 2'b00};
  assign hit_wpc  = avs_address == {slcd_pkg::IDX_WPC, 2'b00};
  assign word_idx = avs_address[4:2];
  assign wbyte    = avs_writedata[7:0];

  // One wait cycle per access; a write lands at the edge that samples waitrequest low,
  // so a master that drops its request early never half-writes a register.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q; // R05
    end
  end

  assign avs_waitrequest = req & ~ack_q;

  // Read data is captured during the wait cycle; unmapped reads give zero.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rdata_q <= 32'h0000_0000;
    end else if (avs_read & ~ack_q) begin
      rdata_q <= 32'h0000_0000;
      if (hit_ram) begin
        rdata_q <= {ram_q[{word_idx, 2'b11}], ram_q[{word_idx, 2'b10}],
                    ram_q[{word_idx, 2'b01}], ram_q[{word_idx, 2'b00}]};
      end else if (hit_pdc) begin
        rdata_q[7:0] <= pdc_q;
      end else if (hit_dc) begin
        rdata_q[7:0] <= dc_q;
      end else if (hit_wpc) begin
        rdata_q[7:0] <= wpc_q;
      end
    end
  end

  assign avs_readdata = rdata_q;

  // Control registers; reserved bits are fixed and ignore writes.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pdc_q <= slcd_pkg::PDC_RESET; // R12
      dc_q  <= slcd_pkg::DC_RESET;  // R13
      wpc_q <= slcd_pkg::WPC_RESET; // R14
    end else if (avs_write & ack_q & avs_byteenable[0]) begin
      if (hit_pdc) begin
        pdc_q <= wbyte;
      end
      if (hit_dc) begin
        dc_q <= wbyte | slcd_pkg::DC_RSV;
      end
      if (hit_wpc) begin
        wpc_q <= wbyte | slcd_pkg::WPC_RSV;
      end
    end
  end

  // Byte lanes let software write single bytes or halfwords.
  always_ff @(posedge sys_clk) begin
    if (avs_write & ack_q & hit_ram) begin
      for (int b = 0; b < 4; b++) begin
        if (avs_byteenable[b]) begin
          ram_q[{word_idx, 2'(b)}] <= avs_writedata[8*b +: 8]; // R04 R05
        end
      end
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < slcd_pkg::RAM_BYTES; gi++) begin : g_flat
      assign ram_flat[8*gi +: 8] = ram_q[gi];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Run gating and frame clock selection.
  logic       run;
  logic       exp_mode;
  logic [2:0] sub_sync_q;
  logic [1:0] wdiv_q;
  logic [7:0] div_q;
  logic       wtick;
  logic       tick;

  // Chip standby, module standby and a cleared enable all stop refresh.
  assign run = dc_q.controller_enable & ~standby_mode & ~module_standby; // R08 R10 R21
  // Expansion is honoured only with every driver group off.
  assign exp_mode = pdc_q.expansion_pin_select & (pdc_q.sgs == 4'h0); // R23

  // The sub clock is asynchronous; only the second and third stages feed the edge test.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sub_sync_q <= 3'h0;
    end else begin
      sub_sync_q <= {sub_sync_q[1:0], subclk_in};
    end
  end

  assign wtick = sub_sync_q[1] & ~sub_sync_q[2];

  // Prescalers run only while refreshing, so a halt freezes the phase.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      div_q  <= 8'h00;
      wdiv_q <= 2'h0;
    end else if (run) begin
      div_q <= div_q + 8'h01;
      if (wtick) begin
        wdiv_q <= wdiv_q + 2'h1;
      end
    end
  end

  // Eleven sources: the sub clock /1, /2, /4 and the system clock /2 to /256.
  always_comb begin
    logic [8:0] mask;
    mask = 9'h000;
    tick = 1'b0;
    if (!dc_q.cks[3]) begin
      if (dc_q.cks[1]) begin
        tick = wtick & (&wdiv_q);
      end else if (dc_q.cks[0]) begin
        tick = wtick & wdiv_q[0];
      end else begin
        tick = wtick;
      end
    end else begin
      mask = (9'h002 << dc_q.cks[2:0]) - 9'h001; // R09
      tick = (({1'b0, div_q} & mask) == mask);
    end
    tick = tick & run;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Line sequencing and alternation.
  logic [1:0]  com_q;
  logic [1:0]  com_next;
  logic        alt_q;
  logic [31:0] seg_data_q;
  logic [31:0] seg_data_d;
  logic        busy;

  assign busy     = state_q != slcd_pkg::ST_IDLE;
  assign com_next = (com_q == pdc_q.duty) ? 2'h0 : com_q + 2'h1;

  // A line starts on each frame tick; in expansion a busy shifter skips it.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      com_q <= 2'h0;
      alt_q <= 1'b0;
    end else if (tick & ~(exp_mode & busy)) begin
      com_q <= com_next; // R19
      if (wpc_q.waveform_type_select || com_next == 2'h0) begin
        alt_q <= ~alt_q; // R11 R24 R26
      end
    end
  end

  // Segment states for the next line; blanking forces all segments off.
  always_comb begin
    seg_data_d = 32'h0000_0000;
    for (int s = 0; s < slcd_pkg::SEG_N; s++) begin
      seg_data_d[s] = ram_flat[ram_index(9'(s), com_next, pdc_q.duty)]; // R20
    end
    if (!dc_q.show_ram_contents) begin
      seg_data_d = 32'h0000_0000; // R22
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      seg_data_q <= 32'h0000_0000;
    end else if (tick & ~exp_mode) begin
      seg_data_q <= seg_data_d; // R01
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial feed for the external segment driver.
  logic [8:0] bit_q;
  logic       shift_q;
  logic       latch_q;
  logic       sdat_q;
  logic [7:0] sidx;

  assign sidx = ram_index(bit_q, com_q, pdc_q.duty);

  // Each bit takes two cycles: data with the clock low, then the clock high.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_q <= slcd_pkg::ST_IDLE;
      bit_q   <= 9'h000;
      shift_q <= 1'b0;
      latch_q <= 1'b0;
      sdat_q  <= 1'b0;
    end else if (!run || !exp_mode) begin
      state_q <= slcd_pkg::ST_IDLE;
      bit_q   <= 9'h000;
      shift_q <= 1'b0;
      latch_q <= 1'b0;
      sdat_q  <= 1'b0;
    end else begin
      unique case (state_q)
        slcd_pkg::ST_IDLE: begin
          latch_q <= 1'b0;
          bit_q   <= 9'h000;
          if (tick) begin
            state_q <= slcd_pkg::ST_SHIFT_LO;
          end
        end
        slcd_pkg::ST_SHIFT_LO: begin
          shift_q <= 1'b0;
          sdat_q  <= ram_flat[sidx] & dc_q.show_ram_contents; // R18 R22
          state_q <= slcd_pkg::ST_SHIFT_HI;
        end
        slcd_pkg::ST_SHIFT_HI: begin
          shift_q <= 1'b1; // R25
          bit_q   <= bit_q + 9'h001;
          if (bit_q == exp_cap(pdc_q.duty) - 9'h001) begin
            state_q <= slcd_pkg::ST_LATCH; // R01 R02 R03
          end else begin
            state_q <= slcd_pkg::ST_SHIFT_LO;
          end
        end
        slcd_pkg::ST_LATCH: begin
          shift_q <= 1'b0;
          latch_q <= 1'b1; // R25
          state_q <= slcd_pkg::ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drive.
  logic [31:0] seg_pin_q;
  logic [31:0] port_q;
  logic [3:0]  com_pin_q;
  logic [3:0]  com_oh;
  logic [3:0]  grp;
  logic        power_q;

  assign grp    = drv_groups(pdc_q.sgs);
  assign com_oh = 4'h1 << com_q;

  // Port mode is chosen per group of eight; expansion claims the top four pins.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      port_q <= 32'hffff_ffff;
    end else begin
      for (int p = 0; p < slcd_pkg::SEG_N; p++) begin
        port_q[p] <= ~grp[p / slcd_pkg::GRP_W]; // R06
      end
      if (exp_mode) begin
        port_q[slcd_pkg::PIN_LATCH -: 4] <= 4'h0;
      end
    end
  end

  // Level is the segment state against the alternation phase; off when halted.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      seg_pin_q <= 32'h0000_0000;
    end else if (!run) begin
      seg_pin_q <= 32'h0000_0000; // R21
    end else begin
      seg_pin_q <= (seg_data_q ^ {32{alt_q}}) & {{8{grp[3]}}, {8{grp[2]}},
                                                   {8{grp[1]}}, {8{grp[0]}}};
      if (exp_mode) begin
        seg_pin_q[slcd_pkg::PIN_LATCH] <= latch_q; // R15
        seg_pin_q[slcd_pkg::PIN_SHIFT] <= shift_q; // R16
        seg_pin_q[slcd_pkg::PIN_SDATA] <= sdat_q;  // R18
        seg_pin_q[slcd_pkg::PIN_ALT]   <= alt_q;   // R17
      end
    end
  end

  // Unused commons follow used ones when paralleling is on at low duty.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      com_pin_q <= 4'h0;
    end else if (!run) begin
      com_pin_q <= 4'h0;
    end else begin
      com_pin_q <= com_oh ^ {4{alt_q}};
      if (pdc_q.cmx && pdc_q.duty == slcd_pkg::DUTY_STATIC) begin
        com_pin_q <= {4{com_oh[0] ^ alt_q}}; // R07
      end else if (pdc_q.cmx && pdc_q.duty == slcd_pkg::DUTY_HALF) begin
        com_pin_q <= {2{com_oh[1:0] ^ {2{alt_q}}}}; // R07
      end
    end
  end

  // Drive supply needs the power bit, the enable and no standby of either kind.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      power_q <= 1'b0;
    end else begin
      power_q <= dc_q.psw & run; // R21
    end
  end

  assign seg_pin        = seg_pin_q;
  assign seg_port_mode  = port_q;
  assign com_pin        = com_pin_q;
  assign drive_power_on = power_q;
  assign supply_boost   = wpc_q.sups;
  assign charge_duty    = wpc_q.cds;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  sequence s_shift_bit;
    state_q == slcd_pkg::ST_SHIFT_LO ##1 state_q == slcd_pkg::ST_SHIFT_HI;
  endsequence

  sequence s_last_bit;
    s_shift_bit ##0 (bit_q == exp_cap(pdc_q.duty) - 9'h001);
  endsequence

  AST_RESET_VALUES: assert property (@(posedge sys_clk) // R12
    reset |=> pdc_q == slcd_pkg::PDC_RESET && dc_q == slcd_pkg::DC_RESET
              && wpc_q == slcd_pkg::WPC_RESET)
    else $error("Control registers left reset with wrong values.");

  AST_ONE_WAIT: assert property (@(posedge sys_clk) disable iff (reset) // R05
    (req && !ack_q) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("Bus access did not complete after one wait cycle.");

  AST_HALT_POWER: assert property (@(posedge sys_clk) disable iff (reset) // R21
    !dc_q.controller_enable |=> !drive_power_on && seg_pin == 32'h0000_0000)
    else $error("Disabled controller still drives power or segments.");

  AST_STANDBY_HOLD: assert property (@(posedge sys_clk) disable iff (reset) // R08
    (standby_mode || module_standby) |=> $stable(com_q) && $stable(alt_q))
    else $error("Line sequence advanced during standby.");

  AST_BLANK: assert property (@(posedge sys_clk) disable iff (reset) // R22
    (tick && !exp_mode && !dc_q.show_ram_contents) |=> seg_data_q == 32'h0000_0000)
    else $error("Blank display loaded nonzero segment data.");

  AST_LATCH_AFTER_LINE: assert property (@(posedge sys_clk) disable iff (reset) // R25
    (s_last_bit ##0 (run && exp_mode) ##1 (run && exp_mode)) |=> latch_q ##1 !latch_q)
    else $error("Latch pulse missing after the last bit of a line.");

  AST_ALT_B: assert property (@(posedge sys_clk) disable iff (reset) // R26
    (tick && !exp_mode && wpc_q.waveform_type_select) |=> alt_q != $past(alt_q))
    else $error("B waveform did not alternate on a line.");

  AST_CMX_STATIC: assert property (@(posedge sys_clk) disable iff (reset) // R07
    (run && pdc_q.cmx && pdc_q.duty == slcd_pkg::DUTY_STATIC) ##1 run
    |-> com_pin == {4{com_pin[0]}})
    else $error("Paralleled commons differ at static duty.");

  AST_EXP_PINS: assert property (@(posedge sys_clk) disable iff (reset) // R15
    (run && exp_mode) ##1 (run && exp_mode)
    |-> seg_pin[slcd_pkg::PIN_LATCH] == $past(latch_q)
        && seg_pin[slcd_pkg::PIN_SHIFT] == $past(shift_q))
    else $error("Expansion clocks not routed to the top segment pins.");

endmodule

// file: hw/slcd_pkg.sv
package slcd_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register map. Printed offsets are indexes; the byte address is 4x.
  localparam int          ADDR_W     = 18;
  localparam logic [15:0] IDX_PDC    = 16'hffc0;
  localparam logic [15:0] IDX_DC     = 16'hffc1;
  localparam logic [15:0] IDX_WPC    = 16'hffc2;
  localparam logic [17:0] RAM_LIMIT  = 18'h0_0020;
  localparam logic [7:0]  PDC_RESET  = 8'h00;
  localparam logic [7:0]  DC_RESET   = 8'h80;
  localparam logic [7:0]  WPC_RESET  = 8'h60;
  localparam logic [7:0]  DC_RSV     = 8'h80;
  localparam logic [7:0]  WPC_RSV    = 8'h60;
  localparam int          RAM_BYTES  = 32;
  localparam int          SEG_N      = 32;
  localparam int          COM_N      = 4;
  localparam int          GRP_W      = 8;

  // Segment capacity per common line when the expansion driver is used.
  localparam logic [8:0]  CAP_STATIC = 9'h100;
  localparam logic [8:0]  CAP_HALF   = 9'h080;
  localparam logic [8:0]  CAP_MULTI  = 9'h040;

  // Pin positions taken over by the expansion signals.
  localparam int          PIN_LATCH  = 31;
  localparam int          PIN_SHIFT  = 30;
  localparam int          PIN_SDATA  = 29;
  localparam int          PIN_ALT    = 28;

  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [1:0] {
    DUTY_STATIC  = 2'b00,
    DUTY_HALF    = 2'b01,
    DUTY_THIRD   = 2'b10,
    DUTY_QUARTER = 2'b11
  } slcd_duty_type;

  typedef enum logic [1:0] {
    ST_IDLE     = 2'b00,
    ST_SHIFT_LO = 2'b01,
    ST_SHIFT_HI = 2'b10,
    ST_LATCH    = 2'b11
  } slcd_state_type;

  typedef struct packed {
    slcd_duty_type duty;
    logic          cmx;
    logic          expansion_pin_select;
    logic [3:0]    sgs;
  } slcd_pdc_type;

  typedef struct packed {
    logic       rsv;
    logic       psw;
    logic       controller_enable;
    logic       show_ram_contents;
    logic [3:0] cks;
  } slcd_dc_type;

  typedef struct packed {
    logic       waveform_type_select;
    logic [1:0] rsv;
    logic       sups;
    logic [3:0] cds;
  } slcd_wpc_type;

endpackage

// file: test/slcd_exp_partner.sv
`timescale 1ns/10ps
// Expansion driver model: counts shift clocks per latch and alternation flips.
module slcd_exp_partner (
  input  wire logic        sys_clk,
  input  wire logic [31:0] seg_pin,
  output int               latch_n = 0,
  output int               last_count = 0,
  output int               flips = 0
);
  logic [31:0] prev_q = 32'h0000_0000;
  logic        alt_q  = 1'b0;
  int          count  = 0;
  // Edges come from the previous sample, since the pins are registered.
  always @(posedge sys_clk) begin
    prev_q <= seg_pin;
    if (seg_pin[30] && !prev_q[30]) begin
      count <= count + 1;
    end
    if (seg_pin[31] && !prev_q[31]) begin
      last_count <= count;
      count      <= 0;
      latch_n    <= latch_n + 1;
      alt_q      <= seg_pin[28];
      if (seg_pin[28] != alt_q) begin
        flips <= flips + 1;
      end
    end
  end
endmodule

// file: test/test_slcd_controller.sv
`timescale 1ns/10ps
module test_slcd_controller;
  localparam logic [17:0] A_PDC = 18'h3_ff00;
  localparam logic [17:0] A_DC  = 18'h3_ff04;
  localparam logic [17:0] A_WPC = 18'h3_ff08;
  logic        sys_clk = 1'b0;
  logic        reset = 1'b1;
  logic [17:0] avs_address = 18'h0_0000;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [3:0]  avs_byteenable = 4'h0;
  logic [31:0] avs_readdata, seg_pin, seg_port_mode;
  logic        avs_waitrequest, drive_power_on, supply_boost;
  logic        standby_mode = 1'b0;
  logic        module_standby = 1'b0;
  logic        subclk_in = 1'b0;
  logic [3:0]  com_pin, charge_duty, c0;
  logic [31:0] seed = 32'h0000_3d4e;
  logic [7:0]  ram [32];
  logic        show = 1'b1;
  logic [3:0]  sg [6] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h6, 4'h8};
  logic [31:0] pm [6] = '{32'hffff_ffff, 32'hffff_ffff, 32'h00ff_ffff, 32'h0000_ffff,
                          32'h0000_00ff, 32'h0000_0000};
  int          cap [4] = '{256, 128, 64, 64};
  int          error_cnt = 0;
  int          n_checks = 0;
  int          sub_cnt = 0;
  int          latch_n, last_count, flips, l1, f1;

  slcd_controller u_slcd_controller (.sys_clk(sys_clk), .reset(reset),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .standby_mode(standby_mode), .module_standby(module_standby), .subclk_in(subclk_in),
    .seg_pin(seg_pin), .seg_port_mode(seg_port_mode), .com_pin(com_pin),
    .drive_power_on(drive_power_on), .supply_boost(supply_boost), .charge_duty(charge_duty));
  slcd_exp_partner u_slcd_exp_partner (.sys_clk(sys_clk), .seg_pin(seg_pin),
    .latch_n(latch_n), .last_count(last_count), .flips(flips));

  ////////////////////////////////////////////////////////////////////////////
  // Clock, and a slow sub clock that toggles every seven system clock cycles.
  initial begin
    forever #10 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    sub_cnt <= (sub_cnt + 1) % 7;
    if (sub_cnt == 0) subclk_in <= ~subclk_in;
  end
  // A hang ends in the normal closing path.
  initial begin
    repeat (60000) @(posedge sys_clk);
    error_cnt++;
    results();
  end

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic results();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // The request stands until a rising edge samples waitrequest low; data is taken there.
  task automatic bus(input logic rd, input logic [17:0] a, input logic [31:0] d,
                     input logic [3:0] be, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge sys_clk);
    avs_address    <= a;
    avs_writedata  <= d;
    avs_byteenable <= be;
    avs_read       <= rd;
    avs_write      <= !rd;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 40);
    if (avs_waitrequest !== 1'b0) error_cnt++;
    q = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic regw(input logic [17:0] a, input logic [7:0] v);
    logic [31:0] q;
    bus(1'b0, a, {24'h0000_00, v}, 4'h1, q);
  endtask
  task automatic rdchk(input string what, input logic [17:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b1, a, 32'h0000_0000, 4'hf, q);
    chk(what, q, exp);
  endtask
  task automatic ramw(input int w, input logic [31:0] d, input logic [3:0] be);
    logic [31:0] q;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) ram[w * 4 + b] = d[b * 8 +: 8];
    end
    bus(1'b0, 18'(w * 4), d, be, q);
  endtask
  // Decode common and polarity from the commons, then predict every segment.
  task automatic scan(input int duty);
    int k, c, idx;
    logic alt;
    logic [31:0] exp;
    repeat (60) begin
      repeat (3) @(negedge sys_clk);
      k = $countones(com_pin);
      alt = (k == 3);
      c = 0;
      for (int i = 0; i < 4; i++) begin
        if (com_pin[i] != alt) c = i;
      end
      for (int s = 0; s < 32; s++) begin
        idx = (duty == 0) ? s : (duty == 1) ? 2 * s + c : 4 * s + c;
        exp[s] = (show & ram[idx / 8][idx % 8]) ^ alt;
      end
      chk("com active", 32'(k == 1 || k == 3), 32'h0000_0001);
      chk("seg_pin", seg_pin, exp);
    end
  endtask
  task automatic waitl(input int target);
    int n;
    n = 0;
    while (latch_n < target && n < 4000) begin
      @(posedge sys_clk);
      n++;
    end
    if (latch_n < target) error_cnt++;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge sys_clk);
    reset <= 1'b0;
    rdchk("pdc", A_PDC, 32'h0000_0000);
    rdchk("dc", A_DC, 32'h0000_0080);
    rdchk("wpc", A_WPC, 32'h0000_0060);
    chk("port mode", seg_port_mode, 32'hffff_ffff);
    regw(A_WPC, 8'h9a);
    rdchk("wpc rw", A_WPC, 32'h0000_00fa);
    chk("charge", 32'(charge_duty), 32'h0000_000a);
    chk("boost", 32'(supply_boost), 32'h0000_0001);
    regw(18'h0_0040, 8'h55);
    rdchk("unmapped", 18'h0_0040, 32'h0000_0000);
    for (int w = 0; w < 8; w++) ramw(w, rnd(), 4'hf);
    repeat (12) ramw(rnd() % 8, rnd(), sg[1 + rnd() % 4] | 4'(rnd() % 4 == 0 ? 3 : 0));
    for (int w = 0; w < 8; w++) begin
      rdchk("ram", 18'(w * 4), {ram[w * 4 + 3], ram[w * 4 + 2], ram[w * 4 + 1], ram[w * 4]});
    end
    for (int i = 0; i < 6; i++) begin
      regw(A_PDC, {4'h0, sg[i]});
      repeat (3) @(negedge sys_clk);
      chk("port mode", seg_port_mode, pm[i]);
    end
    regw(A_PDC, 8'h10);
    repeat (3) @(negedge sys_clk);
    chk("exp port mode", seg_port_mode, 32'h0fff_ffff);
    // Each duty, with the sub clock once and waveform B once.
    for (int d = 0; d < 4; d++) begin
      regw(A_WPC, (d == 3) ? 8'h80 : 8'h00);
      regw(A_PDC, 8'(d * 64 + 8));
      regw(A_DC, (d == 1) ? 8'h70 : 8'h7b);
      repeat (40) @(posedge sys_clk);
      scan(d);
    end
    // Static duty with paralleled commons: all four commons carry one waveform.
    regw(A_PDC, 8'h28);
    repeat (40) @(posedge sys_clk);
    chk("cmx com", 32'(com_pin == 4'h0 || com_pin == 4'hf), 32'h0000_0001);
    regw(A_PDC, 8'hc8);
    chk("power", 32'(drive_power_on), 32'h0000_0001);
    show = 1'b0;
    regw(A_DC, 8'h6b);
    repeat (40) @(posedge sys_clk);
    scan(3);
    @(posedge sys_clk);
    standby_mode <= 1'b1;
    repeat (4) @(negedge sys_clk);
    c0 = com_pin;
    chk("standby power", 32'(drive_power_on), 32'h0000_0000);
    repeat (40) @(negedge sys_clk);
    chk("standby com", 32'(com_pin), 32'(c0));
    @(posedge sys_clk);
    standby_mode   <= 1'b0;
    module_standby <= 1'b1;
    repeat (4) @(negedge sys_clk);
    c0 = com_pin;
    repeat (40) @(negedge sys_clk);
    chk("module standby com", 32'(com_pin), 32'(c0));
    @(posedge sys_clk);
    module_standby <= 1'b0;
    regw(A_DC, 8'h5b);
    repeat (4) @(negedge sys_clk);
    chk("halt power", 32'(drive_power_on), 32'h0000_0000);
    chk("halt seg", seg_pin, 32'h0000_0000);
    chk("halt com", 32'(com_pin), 32'h0000_0000);
    rdchk("kept dc", A_DC, 32'h0000_00db);
    rdchk("kept pdc", A_PDC, 32'h0000_00c8);
    // Expansion path at every duty with waveform B.
    show = 1'b1;
    for (int d = 0; d < 4; d++) begin
      regw(A_DC, 8'h5b);
      regw(A_PDC, 8'(d * 64 + 16));
      regw(A_DC, 8'h78);
      waitl(latch_n + 2);
      l1 = latch_n;
      f1 = flips;
      waitl(l1 + 1);
      chk("shift count", 32'(last_count), 32'(cap[d]));
      chk("alt flips", 32'(flips - f1), 32'(latch_n - l1));
    end
    results();
  end
endmodule
